// ===== src/mcsig_consts.svh
// Constants of the motion completion signalling block.
`ifndef MCSIG_CONSTS_SVH
`define MCSIG_CONSTS_SVH
`define MCSIG_OFS_REGEN_VALUE    12'h168
`define MCSIG_OFS_REGEN_CAP      12'h16a
`define MCSIG_OFS_WINDOW         12'h16c
`define MCSIG_OFS_OUT_SELECT     12'h180
`define MCSIG_OFS_DELAY          12'h184
`define MCSIG_OFS_CONTROL        12'h188
`define MCSIG_OFS_STATUS         12'h18c
`define MCSIG_OFS_IRQ_STATUS     12'h190
`define MCSIG_OFS_IRQ_MASK       12'h194
`define MCSIG_OFS_DO_SELECT      12'h198
`define MCSIG_OFS_PROFILE        12'h19c
`define MCSIG_LATCH_BIT          0
`define MCSIG_ALARM_BIT          4
`define MCSIG_WINDOW_RESET       32'h00003200
`define MCSIG_WINDOW_MAX         32'h00138800
`define MCSIG_DO_CODE_MC         8'h17
`define MCSIG_STEP_RESET         32'h00000010
`endif

// ===== src/mcsig_pkg.sv
// Types of the motion completion signalling block.
package mcsig_pkg;
    typedef enum logic [2:0] {
        MCSIG_IDLE  = 3'b001,
        MCSIG_MOVE  = 3'b010,
        MCSIG_DELAY = 3'b100
    } mcsig_gen_e;
    typedef struct packed {
        logic cmd_done;
        logic in_position;
        logic motion_complete;
        logic deviation;
    } mcsig_flags_s;
endpackage : mcsig_pkg

// ===== src/mcsig_profile.sv
// Profiled position command generator with done delay.
`timescale 1ns/100ps
`include "mcsig_consts.svh"
module mcsig_profile (
    input  wire logic               clock_i,
    input  wire logic               rst_i,
    input  wire logic               trigger_i,
    input  wire logic signed [31:0] target_i,
    input  wire logic        [31:0] step_i,
    input  wire logic        [15:0] delay_i,
    output logic signed      [31:0] command_o,
    output logic                    start_o,
    output logic                    done_o
);
    mcsig_pkg::mcsig_gen_e state;
    mcsig_pkg::mcsig_gen_e next_state;
    logic signed [31:0] next_command;
    logic        [15:0] count;
    logic        [15:0] next_count;
    logic               next_done;
    logic signed [31:0] diff;
    logic signed [31:0] stp;

    always_comb
    begin
        next_state   = state;
        next_command = command_o;
        next_count   = count;
        next_done    = done_o;
        diff         = target_i - command_o;
        stp          = (step_i == 32'h0) ? 32'sh1 : $signed({1'b0, step_i[30:0]});
        if (trigger_i)
        begin
            next_state = mcsig_pkg::MCSIG_MOVE;
            next_done  = 1'b0;
        end
        else
        begin
            unique case (state)
                mcsig_pkg::MCSIG_IDLE:
                begin
                end
                mcsig_pkg::MCSIG_MOVE:
                begin
                    if (diff > stp)
                        next_command = command_o + stp;
                    else if (diff < -stp)
                        next_command = command_o - stp;
                    else
                    begin
                        next_command = target_i;
                        next_count   = delay_i;
                        next_state   = mcsig_pkg::MCSIG_DELAY;
                    end
                end
                mcsig_pkg::MCSIG_DELAY:
                begin
                    if (count == 16'h0)
                    begin
                        next_done  = 1'b1;
                        next_state = mcsig_pkg::MCSIG_IDLE;
                    end
                    else
                        next_count = count - 16'h1;
                end
                default:
                    next_state = mcsig_pkg::MCSIG_IDLE;
            endcase
        end
    end

    assign start_o = trigger_i;

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state     <= mcsig_pkg::MCSIG_IDLE;
            command_o <= 32'sh0;
            count     <= 16'h0;
            done_o    <= 1'b0;
        end
        else
        begin
            state     <= next_state;
            command_o <= next_command;
            count     <= next_count;
            done_o    <= next_done;
        end
    end
endmodule : mcsig_profile

// ===== src/mcsig_top.sv
// Motion completion signalling with register port and interrupt.
`timescale 1ns/100ps
`include "mcsig_consts.svh"
module mcsig_top (
    input  wire logic               clock_i,
    input  wire logic               rst_i,
    input  wire logic        [11:0] addr_i,
    input  wire logic        [31:0] wdata_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    output logic             [31:0] rdata_o,
    input  wire logic               trigger_i,
    input  wire logic signed [31:0] target_i,
    input  wire logic signed [31:0] feedback_i,
    input  wire logic signed [31:0] pulse_error_i,
    input  wire logic               pulse_train_mode_i,
    output logic signed      [31:0] command_o,
    output logic                    motion_complete_flag_o,
    output logic                    in_position_flag_o,
    output logic                    deviation_alarm_o,
    output logic                    do_motion_complete_o,
    output logic                    irq_o
);
    logic [15:0] regen_resistor_value;
    logic [15:0] regen_resistor_capacity;
    logic [31:0] in_position_window;
    logic [15:0] completion_output_select;
    logic [15:0] command_done_delay;
    logic [31:0] profile_step;
    logic [7:0]  do_select;
    logic [2:0]  irq_status;
    logic [2:0]  irq_mask;
    logic [15:0] next_regen_value;
    logic [15:0] next_regen_cap;
    logic [31:0] next_window;
    logic [15:0] next_out_select;
    logic [15:0] next_delay;
    logic [31:0] next_step;
    logic [7:0]  next_do_select;
    logic [2:0]  next_irq_status;
    logic [2:0]  next_irq_mask;
    logic [31:0] next_rdata;

    mcsig_pkg::mcsig_flags_s flags;
    mcsig_pkg::mcsig_flags_s next_flags;
    logic        completed_once;
    logic        next_completed_once;
    logic        alarm;
    logic        next_alarm;
    logic        prof_start;
    logic        prof_done;
    logic        latch_sel;
    logic        alarm_sel;
    logic        in_pos_now;
    logic        mc_now;
    logic [31:0] err_mag;
    logic signed [31:0] err;
    logic signed [31:0] prof_cmd;
    logic [2:0]  events;
    logic [2:0]  flag_level;
    logic [2:0]  next_flag_level;

    mcsig_profile u_profile (
        .clock_i   (clock_i),
        .rst_i     (rst_i),
        .trigger_i (trigger_i),
        .target_i  (target_i),
        .step_i    (profile_step),
        .delay_i   (command_done_delay),
        .command_o (prof_cmd),
        .start_o   (prof_start),
        .done_o    (prof_done)
    );

    assign latch_sel = completion_output_select[`MCSIG_LATCH_BIT];
    assign alarm_sel = completion_output_select[`MCSIG_ALARM_BIT];

    // Completion flags.
    always_comb
    begin
        err      = prof_cmd - feedback_i;
        err_mag  = err[31] ? 32'(-err) : 32'(err);
        in_pos_now = 1'b0;
        if (pulse_train_mode_i)
        begin
            in_pos_now = (pulse_error_i[31] ? 32'(-pulse_error_i) : 32'(pulse_error_i)) < in_position_window;
        end
        else
        begin
            in_pos_now = err_mag <= in_position_window;
        end
        next_flags          = flags;
        next_completed_once = completed_once;
        next_alarm          = alarm;
        mc_now              = 1'b0;
        next_flags.cmd_done    = prof_done;
        next_flags.in_position = in_pos_now;
        if (latch_sel)
        begin
            mc_now = flags.motion_complete | (prof_done & in_pos_now);
        end
        else
        begin
            mc_now = prof_done & in_pos_now;
        end
        next_flags.motion_complete = mc_now;
        // detect lost completion
        // Only a loss after completion counts, so the approach to the target never trips the alarm.
        next_flags.deviation = completed_once & (~in_pos_now | (~latch_sel & ~mc_now));
        if (mc_now)
        begin
            next_completed_once = 1'b1;
        end
        if (next_flags.deviation & alarm_sel)
        begin
            next_alarm = 1'b1;
        end
        if (prof_start)
        begin
            next_flags.cmd_done        = 1'b0;
            next_flags.in_position     = 1'b0;
            next_flags.motion_complete = 1'b0;
            next_flags.deviation       = 1'b0;
            next_completed_once        = 1'b0;
            next_alarm                 = 1'b0;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            flags          <= '0;
            completed_once <= 1'b0;
            alarm          <= 1'b0;
        end
        else
        begin
            flags          <= next_flags;
            completed_once <= next_completed_once;
            alarm          <= next_alarm;
        end
    end

    assign flag_level      = {flags.deviation, flags.in_position, flags.motion_complete};
    assign next_flag_level = {next_flags.deviation, next_flags.in_position, next_flags.motion_complete};

    // Each status bit takes the rising edge of its flag, so a write one clear
    // sticks while the flag itself stays high.
    generate
        for (genvar i = 0; i < 3; i++)
        begin : g_event
            assign events[i] = next_flag_level[i] & ~flag_level[i];
        end
    endgenerate

    // Configuration registers. Writes to unmapped offsets are ignored.
    always_comb
    begin
        next_regen_value = regen_resistor_value;
        next_regen_cap   = regen_resistor_capacity;
        next_window      = in_position_window;
        next_out_select  = completion_output_select;
        next_delay       = command_done_delay;
        next_step        = profile_step;
        next_do_select   = do_select;
        if (wr_i)
        begin
            unique case (addr_i)
                `MCSIG_OFS_REGEN_VALUE:
                begin
                    next_regen_value = wdata_i[15:0];
                end
                `MCSIG_OFS_REGEN_CAP:
                begin
                    next_regen_cap = wdata_i[15:0];
                end
                `MCSIG_OFS_WINDOW:
                begin
                    next_window = (wdata_i > `MCSIG_WINDOW_MAX) ? `MCSIG_WINDOW_MAX : wdata_i;
                end
                `MCSIG_OFS_OUT_SELECT:
                begin
                    // Only the latch and alarm digits exist, so the other digits always read zero.
                    next_out_select = wdata_i[15:0] & 16'h0011;
                end
                `MCSIG_OFS_DELAY:
                begin
                    next_delay = wdata_i[15:0];
                end
                `MCSIG_OFS_PROFILE:
                begin
                    next_step = wdata_i;
                end
                `MCSIG_OFS_DO_SELECT:
                begin
                    next_do_select = wdata_i[7:0];
                end
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            regen_resistor_value     <= 16'h0;
            regen_resistor_capacity  <= 16'h0;
            in_position_window       <= `MCSIG_WINDOW_RESET;
            completion_output_select <= 16'h0;
            command_done_delay       <= 16'h0;
            profile_step             <= `MCSIG_STEP_RESET;
            do_select                <= 8'h0;
        end
        else
        begin
            regen_resistor_value     <= next_regen_value;
            regen_resistor_capacity  <= next_regen_cap;
            in_position_window       <= next_window;
            completion_output_select <= next_out_select;
            command_done_delay       <= next_delay;
            profile_step             <= next_step;
            do_select                <= next_do_select;
        end
    end

    // Interrupt status and mask. An event and a write one clear in the same
    // cycle leave the bit set, so no event is lost to a late clear.
    always_comb
    begin
        next_irq_mask   = irq_mask;
        next_irq_status = irq_status;
        if (wr_i && addr_i == `MCSIG_OFS_IRQ_MASK)
        begin
            next_irq_mask = wdata_i[2:0];
        end
        if (wr_i && addr_i == `MCSIG_OFS_IRQ_STATUS)
        begin
            next_irq_status = irq_status & ~wdata_i[2:0];
        end
        next_irq_status = next_irq_status | events;
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            irq_status <= 3'h0;
            irq_mask   <= 3'h0;
        end
        else
        begin
            irq_status <= next_irq_status;
            irq_mask   <= next_irq_mask;
        end
    end

    // Read data stands for one cycle after the strobe and is zero otherwise,
    // so a reader that samples late sees zero rather than stale contents.
    always_comb
    begin
        next_rdata = 32'h0;
        if (rd_i)
        begin
            unique case (addr_i)
                `MCSIG_OFS_REGEN_VALUE:
                begin
                    next_rdata = {16'h0, regen_resistor_value};
                end
                `MCSIG_OFS_REGEN_CAP:
                begin
                    next_rdata = {16'h0, regen_resistor_capacity};
                end
                `MCSIG_OFS_WINDOW:
                begin
                    next_rdata = in_position_window;
                end
                `MCSIG_OFS_OUT_SELECT:
                begin
                    next_rdata = {16'h0, completion_output_select};
                end
                `MCSIG_OFS_DELAY:
                begin
                    next_rdata = {16'h0, command_done_delay};
                end
                `MCSIG_OFS_PROFILE:
                begin
                    next_rdata = profile_step;
                end
                `MCSIG_OFS_DO_SELECT:
                begin
                    next_rdata = {24'h0, do_select};
                end
                `MCSIG_OFS_STATUS:
                begin
                    next_rdata = {27'h0, alarm, flags};
                end
                `MCSIG_OFS_IRQ_STATUS:
                begin
                    next_rdata = {29'h0, irq_status};
                end
                `MCSIG_OFS_IRQ_MASK:
                begin
                    next_rdata = {29'h0, irq_mask};
                end
                default:
                begin
                    next_rdata = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            rdata_o <= 32'h0;
        end
        else
        begin
            rdata_o <= next_rdata;
        end
    end

    assign command_o              = prof_cmd;
    assign motion_complete_flag_o = flags.motion_complete;
    assign in_position_flag_o     = flags.in_position;
    assign deviation_alarm_o      = alarm;
    assign do_motion_complete_o   = (do_select == `MCSIG_DO_CODE_MC) & flags.motion_complete;
    assign irq_o                  = |(irq_status & irq_mask);
endmodule : mcsig_top

// ===== testbench/mcsig_monitor.sv
// Assertion checker for the motion completion signalling block.
`timescale 1ns/100ps
`include "mcsig_consts.svh"
module mcsig_monitor (
    input wire logic               clock_i,
    input wire logic               rst_i,
    input wire logic        [11:0] addr_i,
    input wire logic        [31:0] wdata_i,
    input wire logic               wr_i,
    input wire logic               trigger_i,
    input wire logic signed [31:0] command_o,
    input wire logic               motion_complete_flag_o,
    input wire logic               in_position_flag_o,
    input wire logic               deviation_alarm_o,
    input wire logic               do_motion_complete_o,
    input wire logic               irq_o
);
    logic latch_on;
    logic alarm_on;
    // Shadow of the completion select field, since the checker sees only the port.
    always_ff @(posedge clock_i or posedge rst_i)
        if (rst_i)
        begin
            latch_on <= 1'b0;
            alarm_on <= 1'b0;
        end
        else if (wr_i && addr_i == `MCSIG_OFS_OUT_SELECT)
        begin
            latch_on <= wdata_i[`MCSIG_LATCH_BIT];
            alarm_on <= wdata_i[`MCSIG_ALARM_BIT];
        end
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    trig_clear_a: assert property (trigger_i |=> !motion_complete_flag_o && !deviation_alarm_o)
        else $error("trigger did not clear the completion flags");
    nolatch_drop_a: assert property (!latch_on && $fell(in_position_flag_o) |-> ##[0:1] !motion_complete_flag_o)
        else $error("non latching completion outlived in position");
    latch_hold_a: assert property (latch_on && motion_complete_flag_o && !trigger_i |=> motion_complete_flag_o)
        else $error("latched completion dropped without trigger");
    alarm_gate_a: assert property ($rose(deviation_alarm_o) |-> alarm_on)
        else $error("deviation alarm raised while disabled");
    alarm_hold_a: assert property (deviation_alarm_o && !trigger_i |=> deviation_alarm_o)
        else $error("deviation alarm dropped without trigger");
    do_map_a: assert property (do_motion_complete_o |-> motion_complete_flag_o)
        else $error("digital output set without completion");
    mc_rise_a: assert property ($rose(motion_complete_flag_o) |-> in_position_flag_o)
        else $error("completion rose outside the window");
    // The bench leaves the step register at its reset value, so that value bounds each move.
    step_limit_a: assert property (!trigger_i |=> ((command_o - $past(command_o)) <= $signed(`MCSIG_STEP_RESET))
        && (($past(command_o) - command_o) <= $signed(`MCSIG_STEP_RESET)))
        else $error("command jumped by more than one step");
    cover property (latch_on && $rose(motion_complete_flag_o));
    cover property ($rose(deviation_alarm_o));
    cover property ($rose(irq_o));
endmodule : mcsig_monitor
bind mcsig_top mcsig_monitor u_mcsig_monitor (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .trigger_i(trigger_i), .command_o(command_o),
    .motion_complete_flag_o(motion_complete_flag_o), .in_position_flag_o(in_position_flag_o),
    .deviation_alarm_o(deviation_alarm_o), .do_motion_complete_o(do_motion_complete_o), .irq_o(irq_o));

// ===== testbench/mcsig_plant.sv
// Axis model that follows the profiled command and reports its error.
`timescale 1ns/100ps
module mcsig_plant (
    input  wire logic               clock_i,
    input  wire logic               rst_i,
    input  wire logic               slow_i,
    input  wire logic signed [31:0] command_i,
    input  wire logic signed [31:0] offset_i,
    output logic signed      [31:0] feedback_o,
    output logic signed      [31:0] pulse_error_o
);
    logic signed [31:0] shaft;
    // A slow axis creeps one pulse a cycle, so completion waits on the axis, not the command.
    always_ff @(posedge clock_i or posedge rst_i)
        if (rst_i)
            shaft <= 32'sh0;
        else if (!slow_i || shaft == command_i)
            shaft <= command_i;
        else
            shaft <= (command_i > shaft) ? shaft + 32'sh1 : shaft - 32'sh1;
    assign feedback_o = shaft - offset_i;
    assign pulse_error_o = command_i - feedback_o;
endmodule : mcsig_plant

// ===== testbench/testbench.sv
// Self-checking bench for the motion completion signalling block.
`timescale 1ns/100ps
`include "mcsig_consts.svh"
module testbench;
    logic               clock_i = 1'b0;
    logic               rst_i   = 1'b1;
    logic        [11:0] addr_i  = 12'h0;
    logic        [31:0] wdata_i = 32'h0;
    logic               wr_i    = 1'b0;
    logic               rd_i    = 1'b0;
    logic               trigger_i = 1'b0;
    logic signed [31:0] target_i  = 32'sh0;
    logic signed [31:0] offset    = 32'sh0;
    logic               slow      = 1'b0;
    logic               ptm       = 1'b0;
    logic               rd_d      = 1'b0;
    logic        [31:0] rdata_o;
    logic signed [31:0] feedback_i, pulse_error_i, command_o, tgt;
    logic               mc, inpos, alarm, do_mc, irq;
    logic        [31:0] exp_q[$];
    int                 err_count = 0;
    int                 total_checks = 0;
    int                 cycles = 0;
    integer             seed = 97;
    mcsig_top u_mcsig_top (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .trigger_i(trigger_i), .target_i(target_i), .feedback_i(feedback_i),
        .pulse_error_i(pulse_error_i), .pulse_train_mode_i(ptm), .command_o(command_o),
        .motion_complete_flag_o(mc), .in_position_flag_o(inpos), .deviation_alarm_o(alarm),
        .do_motion_complete_o(do_mc), .irq_o(irq));
    mcsig_plant u_mcsig_plant (.clock_i(clock_i), .rst_i(rst_i), .slow_i(slow), .command_i(command_o),
        .offset_i(offset), .feedback_o(feedback_i), .pulse_error_o(pulse_error_i));
    initial forever #2.5 clock_i = ~clock_i;
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i    <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock_i);
        rd_i   <= 1'b0;
    endtask : reg_rd
    task automatic move(input logic signed [31:0] t);
        @(posedge clock_i);
        target_i  <= t;
        trigger_i <= 1'b1;
        @(posedge clock_i);
        trigger_i <= 1'b0;
        @(posedge clock_i);
        check(mc, 1'b0);
        check(alarm, 1'b0);
        repeat (3000) if (mc !== 1'b1) @(posedge clock_i);
        repeat (4) @(posedge clock_i);
        check(command_o, t);
    endtask : move
    // Read data stands only in the cycle after the strobe, so it is taken there.
    always @(posedge clock_i)
    begin
        if (rd_d && exp_q.size() > 0)
            check(rdata_o, exp_q.pop_front());
        rd_d <= rd_i;
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            stop_test();
        end
    end
    initial
    begin
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        reg_rd(`MCSIG_OFS_WINDOW, `MCSIG_WINDOW_RESET);
        reg_wr(`MCSIG_OFS_WINDOW, 32'h00200000);
        reg_rd(`MCSIG_OFS_WINDOW, `MCSIG_WINDOW_MAX);
        reg_rd(12'h010, 32'h0);
        reg_wr(`MCSIG_OFS_REGEN_VALUE, 32'h5a5a02ee);
        reg_rd(`MCSIG_OFS_REGEN_VALUE, 32'h000002ee);
        reg_wr(`MCSIG_OFS_REGEN_CAP, 32'ha5a50bb8);
        reg_rd(`MCSIG_OFS_REGEN_CAP, 32'h00000bb8);
        reg_rd(`MCSIG_OFS_PROFILE, `MCSIG_STEP_RESET);
        reg_wr(`MCSIG_OFS_OUT_SELECT, 32'h000000ff);
        reg_rd(`MCSIG_OFS_OUT_SELECT, 32'h00000011);
        $display("test registers done");
        reg_wr(`MCSIG_OFS_WINDOW, 32'h5);
        reg_wr(`MCSIG_OFS_OUT_SELECT, 32'h0);
        reg_wr(`MCSIG_OFS_DO_SELECT, {24'h0, `MCSIG_DO_CODE_MC});
        reg_wr(`MCSIG_OFS_IRQ_MASK, 32'h4);
        reg_wr(`MCSIG_OFS_DELAY, $random(seed) & 32'h7);
        tgt = ($random(seed) & 32'h1ff) + 32'sd32;
        move(tgt);
        check(mc, 1'b1);
        check(do_mc, 1'b1);
        reg_wr(`MCSIG_OFS_DO_SELECT, 32'h0);
        @(posedge clock_i);
        check(do_mc, 1'b0);
        reg_wr(`MCSIG_OFS_DO_SELECT, {24'h0, `MCSIG_DO_CODE_MC});
        // An error equal to the window is inside in register mode, outside in pulse mode.
        offset <= 32'sh5;
        repeat (4) @(posedge clock_i);
        check(inpos, 1'b1);
        ptm <= 1'b1;
        repeat (4) @(posedge clock_i);
        check(inpos, 1'b0);
        check(mc, 1'b0);
        check(alarm, 1'b0);
        reg_rd(`MCSIG_OFS_STATUS, 32'h09);
        offset <= 32'sh4;
        repeat (4) @(posedge clock_i);
        check(inpos, 1'b1);
        check(irq, 1'b1);
        reg_wr(`MCSIG_OFS_IRQ_MASK, 32'h0);
        @(posedge clock_i);
        check(irq, 1'b0);
        reg_wr(`MCSIG_OFS_IRQ_MASK, 32'h4);
        @(posedge clock_i);
        check(irq, 1'b1);
        reg_wr(`MCSIG_OFS_IRQ_STATUS, 32'h7);
        @(posedge clock_i);
        check(irq, 1'b0);
        reg_rd(`MCSIG_OFS_IRQ_STATUS, 32'h0);
        $display("test nonlatch done");
        ptm    <= 1'b0;
        offset <= 32'sh0;
        slow   <= 1'b1;
        reg_wr(`MCSIG_OFS_OUT_SELECT, 32'h11);
        tgt = -(($random(seed) & 32'h1ff) + 32'sd32);
        move(tgt);
        check(mc, 1'b1);
        reg_rd(`MCSIG_OFS_STATUS, 32'h0e);
        offset <= 32'sh40;
        repeat (4) @(posedge clock_i);
        check(inpos, 1'b0);
        check(mc, 1'b1);
        check(alarm, 1'b1);
        offset <= 32'sh0;
        move(32'sh0);
        check(mc, 1'b1);
        $display("test latch done");
        stop_test();
    end
endmodule : testbench
